// *** common/supervisor_regs.svh ***
// register map, field positions, reset values and timing figures of the supervisor block
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ----------------------------------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_CLOCK_POWER_CONFIG   8'hc5
`define IDX_HS_CLOCK_CAL_VALUE   8'he4
`define IDX_WATCHDOG_DISABLE_KEY 8'hd0
`define IDX_EXECUTION_CONTROL    8'hd1
`define IDX_IRQ_STATUS           8'hd2
`define IDX_IRQ_MASK             8'hd3
`define IDX_TIMESTAMP_HOURS      8'he8
`define IDX_TIMESTAMP_MIN_SEC    8'he9

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CPC_TIME_LATCH_MODE      0
`define CPC_CAL_RATE_LSB         1
`define CPC_CAL_RATE_MSB         3
`define CPC_FREQ_SELECT          4
`define EXC_TIME_LATCH_REQUEST   0
`define IRQ_CAL_UPDATED          0
`define IRQ_TIME_LATCHED         1
`define WATCHDOG_KEY             32'h48db_a399
`define CPC_RESET                32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_HZ                 250000000
`define WD_OSC_HZ                10000
`define WD_TIMEOUT_S             13
`define SLOW_CLOCK_HZ            32000
`define WD_TICK_CYCLES           (`CLOCK_HZ / `WD_OSC_HZ)
`define WD_TIMEOUT_TICKS         (`WD_TIMEOUT_S * `WD_OSC_HZ)
`define SECOND_CYCLES            (`CLOCK_HZ)
`define SLOW_TICK_CYCLES         (`CLOCK_HZ / `SLOW_CLOCK_HZ)

`endif

// *** common/supervisor_pkg.sv ***
// types of the supervisor service block
package supervisor_pkg;

    // ----------------------------------------------------------------
    // state of the whole block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] hrdata;
        logic        dp_valid;
        logic        dp_write;
        logic [7:0]  dp_index;
        logic        dp_mapped;
        logic        rd_ready;
        logic        latch_mode;
        logic [2:0]  cal_rate;
        logic        freq_select;
        logic        wd_enabled;
        logic [14:0] wd_div;
        logic [17:0] wd_count;
        logic        chip_reset;
        logic [27:0] sec_div;
        logic [5:0]  elapsed_seconds;
        logic [5:0]  elapsed_minutes;
        logic [17:0] elapsed_hours;
        logic [5:0]  lat_sec;
        logic [5:0]  lat_min;
        logic [17:0] lat_hour;
        logic [6:0]  cal_trig_count;
        logic        cal_request;
        logic        cal_busy;
        logic [31:0] cal_value;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic        strap_taken;
        logic        single_source;
        logic [12:0] slow_div;
        logic        slow_tick;
    } state_s;

endpackage

// *** src/supervisor_service_functions.sv ***
// supervisor service block: watchdog, elapsed-time stamp, clock management, ahb-lite registers
//
// Notes on behaviour
// - watchdog enabled after every reset
// - uncleared watchdog for 13 s resets chip
// - firmware clear restarts watchdog from zero
// - watchdog counts on 10 kHz internal tick
// - exact key disables watchdog, other re-enables
// - free time counter, software reads latches
// - latch mode 0 on request, 1 per second
// - writing one requests latch, zero ignored
// - hours 17:0, minutes 15:8, seconds 7:0
// - low power: fast oscillator on only when needed
// - no 8 MHz while uart in use
// - calibration by sequencer or external command
// - cal rate 0 off, else 1..100 triggers
// - frequency select picks 4 or 8 MHz
// - update flag set by new calibration value
// - single source: 32 kHz derived, fast osc on
// - single source disables the three counters
`timescale 1ns/10ps
`include "supervisor_regs.svh"

module supervisor_service_functions #(
    parameter logic [14:0] WD_TICK_CYCLES   = 15'(`WD_TICK_CYCLES),
    parameter logic [17:0] WD_TIMEOUT_TICKS = 18'(`WD_TIMEOUT_TICKS),
    parameter logic [27:0] SECOND_CYCLES    = 28'(`SECOND_CYCLES),
    parameter logic [12:0] SLOW_TICK_CYCLES = 13'(`SLOW_TICK_CYCLES)
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    // watchdog
    input  wire logic        wdt_clear_i,
    output logic             chip_reset_o,
    // clock management
    input  wire logic        clock_mode_select_pin_i,
    input  wire logic        uart_select_i,
    input  wire logic        measure_request_i,
    input  wire logic        cycle_trigger_i,
    input  wire logic        cal_command_i,
    input  wire logic [31:0] cal_result_i,
    input  wire logic        cal_result_valid_i,
    output logic             cal_request_o,
    output logic             fast_oscillator_enable_o,
    output logic             fast_osc_8mhz_o,
    output logic             slow_tick_o,
    output logic             aux_counters_enable_o,
    // interrupt
    output logic             irq_o
);

    supervisor_pkg::state_s r;
    supervisor_pkg::state_s next_r;

    // ----------------------------------------------------------------
    // calibration interval decode
    // ----------------------------------------------------------------
    function automatic logic [6:0] cal_interval(input logic [2:0] code);
        case (code)
            3'h1:    cal_interval = 7'd1;
            3'h2:    cal_interval = 7'd2;
            3'h3:    cal_interval = 7'd5;
            3'h4:    cal_interval = 7'd10;
            3'h5:    cal_interval = 7'd20;
            3'h6:    cal_interval = 7'd50;
            3'h7:    cal_interval = 7'd100;
            default: cal_interval = 7'd0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // register read view
    // ----------------------------------------------------------------
    function automatic logic [31:0] read_view(input supervisor_pkg::state_s s,
                                              input logic [7:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (idx)
            `IDX_CLOCK_POWER_CONFIG: begin
                v[`CPC_TIME_LATCH_MODE] = s.latch_mode;
                v[`CPC_CAL_RATE_MSB:`CPC_CAL_RATE_LSB] = s.cal_rate;
                v[`CPC_FREQ_SELECT] = s.freq_select;
            end
            `IDX_HS_CLOCK_CAL_VALUE: v = s.cal_value;
            `IDX_IRQ_STATUS:         v[1:0] = s.irq_status;
            `IDX_IRQ_MASK:           v[1:0] = s.irq_mask;
            `IDX_TIMESTAMP_HOURS:    v[17:0] = s.lat_hour;
            `IDX_TIMESTAMP_MIN_SEC: begin
                v[15:8] = {2'h0, s.lat_min};
                v[7:0]  = {2'h0, s.lat_sec};
            end
            default:                 v = 32'h0000_0000;
        endcase
        read_view = v;
    endfunction

    logic        addr_phase;
    logic        wr_phase;
    logic        latch_now;
    logic        second_tick;
    logic [1:0]  irq_set;
    logic [1:0]  irq_clear;
    logic [6:0]  interval;
    logic        wd_restart;

    always_comb begin
        next_r    = r;
        wd_restart = 1'b0;
        irq_set   = 2'h0;
        irq_clear = 2'h0;
        latch_now = 1'b0;
        interval  = cal_interval(r.cal_rate);

        // ------------------------------------------------------------
        // bus slave
        // ------------------------------------------------------------
        // reads take one wait state so that a write just before is seen
        addr_phase = hsel_i && htrans_i[1] && hready_i;
        wr_phase   = r.dp_valid && r.dp_write;
        if (r.dp_valid && !r.dp_write && !r.rd_ready) begin
            next_r.hrdata   = r.dp_mapped ? read_view(r, r.dp_index) : 32'h0000_0000;
            next_r.rd_ready = 1'b1;
        end
        if (hready_i) begin
            next_r.dp_valid  = addr_phase;
            next_r.dp_write  = hwrite_i;
            next_r.dp_index  = haddr_i[9:2];
            next_r.dp_mapped = (haddr_i[31:10] == 22'h0) && (haddr_i[1:0] == 2'h0);
            next_r.rd_ready  = 1'b0;
        end
        if (wr_phase && r.dp_mapped) begin
            case (r.dp_index)
                `IDX_CLOCK_POWER_CONFIG: begin
                    next_r.latch_mode  = hwdata_i[`CPC_TIME_LATCH_MODE];
                    next_r.cal_rate    = hwdata_i[`CPC_CAL_RATE_MSB:`CPC_CAL_RATE_LSB];
                    next_r.freq_select = hwdata_i[`CPC_FREQ_SELECT];
                end
                `IDX_WATCHDOG_DISABLE_KEY: begin
                    next_r.wd_enabled = (hwdata_i != `WATCHDOG_KEY);
                    wd_restart        = 1'b1;
                end
                `IDX_EXECUTION_CONTROL: begin
                    latch_now = hwdata_i[`EXC_TIME_LATCH_REQUEST];
                end
                `IDX_IRQ_STATUS: irq_clear = hwdata_i[1:0];
                `IDX_IRQ_MASK:   next_r.irq_mask = hwdata_i[1:0];
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // clock mode strap
        // ------------------------------------------------------------
        // taken once after reset release; the pin is static in use
        if (!r.strap_taken) begin
            next_r.strap_taken   = 1'b1;
            next_r.single_source = !clock_mode_select_pin_i;
        end

        // ------------------------------------------------------------
        // watchdog
        // ------------------------------------------------------------
        next_r.chip_reset = 1'b0;
        if (r.wd_div >= WD_TICK_CYCLES - 15'd1) begin
            next_r.wd_div = 15'h0;
        end else begin
            next_r.wd_div = r.wd_div + 15'd1;
        end
        // a key write restarts the count even when a tick falls in the same cycle
        if (wdt_clear_i || wd_restart || !r.wd_enabled) begin
            next_r.wd_count = 18'h0;
        end else if (r.wd_div >= WD_TICK_CYCLES - 15'd1) begin
            if (r.wd_count >= WD_TIMEOUT_TICKS - 18'd1) begin
                next_r.wd_count   = 18'h0;
                next_r.chip_reset = 1'b1;
            end else begin
                next_r.wd_count = r.wd_count + 18'd1;
            end
        end

        // ------------------------------------------------------------
        // elapsed time counter
        // ------------------------------------------------------------
        second_tick = 1'b0;
        if (r.single_source) begin
            next_r.sec_div = 28'h0;
        end else if (r.sec_div >= SECOND_CYCLES - 28'd1) begin
            next_r.sec_div = 28'h0;
            second_tick    = 1'b1;
        end else begin
            next_r.sec_div = r.sec_div + 28'd1;
        end
        if (second_tick) begin
            if (r.elapsed_seconds == 6'd59) begin
                next_r.elapsed_seconds = 6'd0;
                if (r.elapsed_minutes == 6'd59) begin
                    next_r.elapsed_minutes  = 6'd0;
                    next_r.elapsed_hours = r.elapsed_hours + 18'd1;
                end else begin
                    next_r.elapsed_minutes = r.elapsed_minutes + 6'd1;
                end
            end else begin
                next_r.elapsed_seconds = r.elapsed_seconds + 6'd1;
            end
        end
        // automatic latch takes the value as it was before this tick
        if (latch_now || (r.latch_mode && second_tick)) begin
            next_r.lat_sec  = r.elapsed_seconds;
            next_r.lat_min  = r.elapsed_minutes;
            next_r.lat_hour = r.elapsed_hours;
            irq_set[`IRQ_TIME_LATCHED] = 1'b1;
        end

        // ------------------------------------------------------------
        // fast oscillator calibration
        // ------------------------------------------------------------
        next_r.cal_request = 1'b0;
        if (cycle_trigger_i && interval != 7'd0) begin
            if (r.cal_trig_count >= interval - 7'd1) begin
                next_r.cal_trig_count = 7'h0;
                next_r.cal_request    = 1'b1;
            end else begin
                next_r.cal_trig_count = r.cal_trig_count + 7'd1;
            end
        end
        if (interval == 7'd0) begin
            next_r.cal_trig_count = 7'h0;
        end
        if (cal_command_i) begin
            next_r.cal_request = 1'b1;
        end
        if (cal_result_valid_i) begin
            next_r.cal_busy  = 1'b0;
            next_r.cal_value = cal_result_i;
            irq_set[`IRQ_CAL_UPDATED] = 1'b1;
        end
        // a new request outranks a result landing in the same cycle
        if (next_r.cal_request) begin
            next_r.cal_busy = 1'b1;
        end

        // ------------------------------------------------------------
        // derived slow clock
        // ------------------------------------------------------------
        next_r.slow_tick = 1'b0;
        if (!r.single_source) begin
            next_r.slow_div = 13'h0;
        end else if (r.slow_div >= SLOW_TICK_CYCLES - 13'd1) begin
            next_r.slow_div  = 13'h0;
            next_r.slow_tick = 1'b1;
        end else begin
            next_r.slow_div = r.slow_div + 13'd1;
        end

        // ------------------------------------------------------------
        // interrupt status, a new event beats a clear in the same cycle
        // ------------------------------------------------------------
        next_r.irq_status = (r.irq_status & ~irq_clear) | irq_set;
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            r                <= '0;
            r.latch_mode     <= 1'(`CPC_RESET >> `CPC_TIME_LATCH_MODE);
            r.freq_select    <= 1'b0;
            r.wd_enabled     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hreadyout_o  = !(r.dp_valid && !r.dp_write && !r.rd_ready);
    assign hresp_o      = 1'b0;
    assign hrdata_o     = r.hrdata;
    assign chip_reset_o = r.chip_reset;
    assign cal_request_o = r.cal_request;
    assign slow_tick_o  = r.slow_tick;
    // fast oscillator runs only for measurements and pending calibrations unless it feeds the slow clock
    assign fast_oscillator_enable_o = r.single_source || measure_request_i || r.cal_busy;
    // the uart baud logic expects 4 MHz, so the 8 MHz choice yields to it
    assign fast_osc_8mhz_o = r.freq_select && !uart_select_i;
    assign aux_counters_enable_o = r.strap_taken && !r.single_source;
    assign irq_o        = |(r.irq_status & r.irq_mask);

endmodule

// *** verification/supervisor_service_functions_checker.sv ***
// concurrent checks on the ports of the supervisor service block
`timescale 1ns/10ps

module supervisor_service_functions_checker (
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       reset_i,
    // bus
    input wire logic       hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic       hwrite_i,
    input wire logic       hready_i,
    input wire logic       hreadyout_o,
    input wire logic       hresp_o,
    // watchdog and clocks
    input wire logic       wdt_clear_i,
    input wire logic       chip_reset_o,
    input wire logic       uart_select_i,
    input wire logic       measure_request_i,
    input wire logic       cal_command_i,
    input wire logic       cal_request_o,
    input wire logic       fast_oscillator_enable_o,
    input wire logic       fast_osc_8mhz_o,
    input wire logic       slow_tick_o,
    input wire logic       aux_counters_enable_o
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_read_taken;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    endsequence
    sequence s_one_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    a_hresp_always_okay: assert property (hresp_o == 1'h0) else $error("response not okay");
    a_read_one_wait: assert property (s_read_taken |=> s_one_wait) else $error("read wait wrong");
    a_write_no_wait: assert property (hsel_i && htrans_i[1] && hready_i && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_cal_cmd_request: assert property (cal_command_i |=> cal_request_o ##1 !cal_request_o)
        else $error("command gave no single request");
    a_cal_osc_on: assert property (cal_request_o |-> fast_oscillator_enable_o)
        else $error("oscillator off for calibration");
    a_measure_osc_on: assert property (measure_request_i |-> fast_oscillator_enable_o)
        else $error("oscillator off for measurement");
    a_uart_no_fast: assert property (uart_select_i |-> !fast_osc_8mhz_o)
        else $error("8 mhz with uart");
    a_wd_reset_pulse: assert property (chip_reset_o |=> !chip_reset_o)
        else $error("chip reset longer than one cycle");
    // a held clear keeps the count at zero, so no timeout can follow
    a_wd_clear_holds: assert property (wdt_clear_i ##1 wdt_clear_i |=> !chip_reset_o)
        else $error("reset despite clear");
    a_slow_tick_single: assert property (slow_tick_o |-> !aux_counters_enable_o)
        else $error("slow tick in low power mode");
    a_single_osc_on: assert property (!$past(reset_i) && !aux_counters_enable_o
        |-> fast_oscillator_enable_o) else $error("oscillator off in single source");
endmodule

bind supervisor_service_functions supervisor_service_functions_checker checker_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .wdt_clear_i(wdt_clear_i), .chip_reset_o(chip_reset_o), .uart_select_i(uart_select_i),
    .measure_request_i(measure_request_i), .cal_command_i(cal_command_i),
    .cal_request_o(cal_request_o), .fast_oscillator_enable_o(fast_oscillator_enable_o),
    .fast_osc_8mhz_o(fast_osc_8mhz_o), .slow_tick_o(slow_tick_o),
    .aux_counters_enable_o(aux_counters_enable_o));

// *** verification/supervisor_service_functions_tb.sv ***
// self-checking bench of the supervisor service block
`timescale 1ns/10ps
`include "supervisor_regs.svh"

module supervisor_service_functions_tb;
    `define CK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
    localparam logic [7:0] CFG = `IDX_CLOCK_POWER_CONFIG, KEY = `IDX_WATCHDOG_DISABLE_KEY,
        EXC = `IDX_EXECUTION_CONTROL, STS = `IDX_IRQ_STATUS, MSK = `IDX_IRQ_MASK,
        MS = `IDX_TIMESTAMP_MIN_SEC, HRS = `IDX_TIMESTAMP_HOURS, CAL = `IDX_HS_CLOCK_CAL_VALUE;
    logic mclk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, wdt_clear_i = 0;
    logic uart_select_i = 0, clock_mode_select_pin_i = 1, measure_request_i = 0;
    logic cycle_trigger_i = 0, cal_command_i = 0, cal_result_valid_i = 0;
    logic [1:0] htrans_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, cal_result_i = 0, hrdata_o;
    logic hreadyout_o, hresp_o, chip_reset_o, cal_request_o, fast_oscillator_enable_o;
    logic fast_osc_8mhz_o, slow_tick_o, aux_counters_enable_o, irq_o;
    int err_count = 0, n_checks = 0, cyc = 0;

    // short counts keep the run small: tick 4, timeout 5 ticks, second 20, slow tick 3
    supervisor_service_functions #(.WD_TICK_CYCLES(15'h4), .WD_TIMEOUT_TICKS(18'h5),
        .SECOND_CYCLES(28'h14), .SLOW_TICK_CYCLES(13'h3)) supervisor_service_functions_inst (
        .mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .wdt_clear_i(wdt_clear_i), .chip_reset_o(chip_reset_o),
        .clock_mode_select_pin_i(clock_mode_select_pin_i), .uart_select_i(uart_select_i),
        .measure_request_i(measure_request_i), .cycle_trigger_i(cycle_trigger_i),
        .cal_command_i(cal_command_i), .cal_result_i(cal_result_i),
        .cal_result_valid_i(cal_result_valid_i), .cal_request_o(cal_request_o),
        .fast_oscillator_enable_o(fast_oscillator_enable_o), .fast_osc_8mhz_o(fast_osc_8mhz_o),
        .slow_tick_o(slow_tick_o), .aux_counters_enable_o(aux_counters_enable_o), .irq_o(irq_o));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    initial forever #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim;
        end
    end

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task clk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // one single transfer; the wait for hready has no cycle count of its own
    task bus(input logic w, input logic [7:0] x, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk_i);
        hsel_i <= 1'h1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {22'h0, x, 2'h0};
        do @(posedge mclk_i); while (hreadyout_o !== 1'h1);
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge mclk_i); while (hreadyout_o !== 1'h1);
        r = hrdata_o;
    endtask

    task count_edges(input int n, output int wd, output int st);
        wd = 0;
        st = 0;
        repeat (n) begin
            @(posedge mclk_i);
            wd += chip_reset_o;
            st += slow_tick_o;
        end
    endtask

    function logic [31:0] tot(input logic [31:0] v);
        return v[15:8] * 60 + v[7:0];
    endfunction

    // answer a pending calibration
    task answer;
        cal_result_valid_i <= 1'h1;
        @(posedge mclk_i) cal_result_valid_i <= 1'h0;
    endtask

    task trig(output logic g);
        @(posedge mclk_i) cycle_trigger_i <= 1'h1;
        @(posedge mclk_i) cycle_trigger_i <= 1'h0;
        @(posedge mclk_i) g = cal_request_o;
        if (g === 1'h1) answer;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        logic [31:0] r;
        bus(1'h0, CFG, 32'h0, r);
        `CK(r, `CPC_RESET)
        bus(1'h0, KEY, 32'h0, r);
        `CK(r, 32'h0)
        bus(1'h1, 8'h10, 32'hffff_ffff, r);
        bus(1'h0, 8'h10, 32'h0, r);
        `CK(r, 32'h0)
        `CK(aux_counters_enable_o, 1'h1)
    endtask

    task t_watchdog;
        int n, w, s;
        logic [31:0] r;
        n = 0;
        while (chip_reset_o !== 1'h1 && n < 60) begin
            @(posedge mclk_i);
            n++;
        end
        `CK(n < 60, 1'h1)
        count_edges(19, w, s);
        `CK(w, 0)
        count_edges(1, w, s);
        `CK(w, 1)
        wdt_clear_i <= 1'h1;
        count_edges(60, w, s);
        `CK(w, 0)
        wdt_clear_i <= 1'h0;
        bus(1'h1, KEY, `WATCHDOG_KEY, r);
        count_edges(60, w, s);
        `CK(w, 0)
        bus(1'h1, KEY, 32'h48db_a398, r);
        count_edges(30, w, s);
        `CK(w, 1)
        bus(1'h1, KEY, `WATCHDOG_KEY, r);
    endtask

    task t_time;
        logic [31:0] a, b;
        bus(1'h0, MS, 32'h0, a);
        `CK(a, 32'h0)
        bus(1'h1, EXC, 32'h0, a);
        bus(1'h0, MS, 32'h0, a);
        `CK(a, 32'h0)
        bus(1'h1, EXC, 32'h1, a);
        bus(1'h0, MS, 32'h0, a);
        clk(33);
        bus(1'h1, EXC, 32'h1, b);
        bus(1'h0, MS, 32'h0, b);
        `CK(tot(b) - tot(a), 2)
        `CK(b[31:16], 16'h0)
        bus(1'h0, HRS, 32'h0, a);
        `CK(a, 32'h0)
        clk(30);
        bus(1'h0, MS, 32'h0, a);
        `CK(a, b)
        `CK(irq_o, 1'h0)
        bus(1'h1, MSK, 32'h2, a);
        clk(1);
        `CK(irq_o, 1'h1)
        bus(1'h1, STS, 32'h2, a);
        clk(1);
        `CK(irq_o, 1'h0)
        bus(1'h1, CFG, 32'h1, a);
        clk(20);
        bus(1'h0, MS, 32'h0, a);
        clk(16);
        bus(1'h0, MS, 32'h0, b);
        `CK(tot(b) - tot(a), 1)
        bus(1'h1, CFG, 32'h0, a);
    endtask

    task t_cal;
        logic [31:0] r;
        logic g;
        int n;
        int e[7];
        e = '{1, 2, 5, 10, 20, 50, 100};
        for (int k = 1; k < 8; k++) begin
            cal_result_i <= 32'h01e8_4800 + 32'(k);
            bus(1'h1, CFG, 32'(k) << 1, r);
            // the first request only aligns the trigger count
            for (int p = 0; p < 2; p++) begin
                n = 0;
                g = 1'h0;
                while (g !== 1'h1 && n < 101) begin
                    trig(g);
                    n++;
                end
            end
            `CK(n, e[k-1])
        end
        bus(1'h0, CAL, 32'h0, r);
        `CK(r, 32'h01e8_4807)
        bus(1'h0, STS, 32'h0, r);
        `CK(r[0], 1'h1)
        bus(1'h1, STS, 32'h1, r);
        bus(1'h0, STS, 32'h0, r);
        `CK(r[0], 1'h0)
        bus(1'h1, CFG, 32'h0, r);
        n = 0;
        repeat (110) begin
            trig(g);
            n += g;
        end
        `CK(n, 0)
        @(posedge mclk_i) cal_command_i <= 1'h1;
        @(posedge mclk_i) cal_command_i <= 1'h0;
        @(posedge mclk_i) `CK(cal_request_o, 1'h1)
        `CK(fast_oscillator_enable_o, 1'h1)
        answer;
        clk(2);
        `CK(fast_oscillator_enable_o, 1'h0)
        measure_request_i <= 1'h1;
        clk(2);
        `CK(fast_oscillator_enable_o, 1'h1)
        measure_request_i <= 1'h0;
        bus(1'h1, CFG, 32'h10, r);
        bus(1'h0, CFG, 32'h0, r);
        `CK(r, 32'h10)
        `CK(fast_osc_8mhz_o, 1'h1)
        uart_select_i <= 1'h1;
        clk(2);
        `CK(fast_osc_8mhz_o, 1'h0)
        uart_select_i <= 1'h0;
    endtask

    task t_single;
        logic [31:0] a, b;
        int w, s;
        clock_mode_select_pin_i <= 1'h0;
        reset_i <= 1'h1;
        clk(1);
        reset_i <= 1'h0;
        clk(2);
        `CK(aux_counters_enable_o, 1'h0)
        `CK(fast_oscillator_enable_o, 1'h1)
        count_edges(30, w, s);
        `CK(s, 10)
        bus(1'h1, EXC, 32'h1, a);
        bus(1'h0, MS, 32'h0, a);
        clk(40);
        bus(1'h1, EXC, 32'h1, b);
        bus(1'h0, MS, 32'h0, b);
        `CK(b, a)
    endtask

    initial begin
        clk(12);
        reset_i <= 1'h0;
        t_regs;
        t_watchdog;
        t_time;
        t_cal;
        t_single;
        end_sim;
    end
endmodule
